/* design/pmc_defines.vh */
// constants for the power-managed mode control block
`ifndef PMC_DEFINES_VH
`define PMC_DEFINES_VH

// register byte offsets
`define PMC_OSC_CTRL_OFS 8'h00
`define PMC_SEC_CTRL_OFS 8'h04
`define PMC_STATUS_OFS 8'h08

// osc_control_register fields
`define PMC_IDLE_BIT 7
`define PMC_IFS_HI 6
`define PMC_IFS_LO 4
`define PMC_PRI_RDY_BIT 3
`define PMC_INT_STB_BIT 2
`define PMC_SCS_HI 1
`define PMC_SCS_LO 0
`define PMC_OSC_CTRL_RST 8'h00

// secondary control register fields
`define PMC_SEC_EN_BIT 3
`define PMC_SEC_ACT_BIT 6
`define PMC_SEC_CTRL_RST 8'h00

// clock source codes
`define PMC_SRC_PRI 2'h0
`define PMC_SRC_SEC 2'h1
`define PMC_SRC_INT 2'h2

// timing
`define PMC_SWITCH_TICKS 4'h8
`define PMC_CLK_PERIOD_NS 10
`define PMC_CPU_START_NS 10000
`define PMC_FAST_STABLE_NS 1000000

// bus responses
`define PMC_RESP_OKAY 2'h0
`define PMC_RESP_DECERR 2'h3

`endif

/* design/pmc_mode_ctrl.v */
// power-managed mode controller with axi4-lite register slave
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "pmc_defines.vh"

module pmc_mode_ctrl #(
	parameter [15:0] CPU_START_CYCLES =
		(`PMC_CPU_START_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS,
	parameter [19:0] FAST_STABLE_CYCLES =
		(`PMC_FAST_STABLE_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS
) (
	// clock and reset
	input wire clk_in,
	input wire rstn_in,
	// axi4-lite write channels
	input wire [7:0] s_axi_awaddr_in,
	input wire s_axi_awvalid_in,
	output wire s_axi_awready_out,
	input wire [31:0] s_axi_wdata_in,
	input wire [3:0] s_axi_wstrb_in,
	input wire s_axi_wvalid_in,
	output wire s_axi_wready_out,
	output reg [1:0] s_axi_bresp_out,
	output reg s_axi_bvalid_out,
	input wire s_axi_bready_in,
	// axi4-lite read channels
	input wire [7:0] s_axi_araddr_in,
	input wire s_axi_arvalid_in,
	output wire s_axi_arready_out,
	output reg [31:0] s_axi_rdata_out,
	output reg [1:0] s_axi_rresp_out,
	output reg s_axi_rvalid_out,
	input wire s_axi_rready_in,
	// cpu core and interrupt logic, same clock
	input wire power_down_in,
	input wire wake_irq_in,
	input wire soft_reset_in,
	input wire wdt_timeout_in,
	input wire wdt_enable_in,
	input wire failsafe_enable_in,
	input wire primary_is_internal_in,
	// oscillator pins, asynchronous
	input wire primary_ready_in,
	input wire secondary_running_in,
	input wire primary_clk_in,
	input wire secondary_clk_in,
	input wire internal_clk_in,
	// clock control
	output reg cpu_clk_en_out,
	output reg periph_clk_en_out,
	output reg [1:0] sys_clk_sel_out,
	output reg primary_osc_en_out,
	output reg secondary_osc_en_out,
	output reg internal_fast_osc_en_out,
	output reg internal_slow_osc_en_out,
	// events
	output reg wdt_reset_out,
	output reg forced_nop_out
);

localparam [2:0] ST_PRIMARY_RUN_MODE = 3'h0;
localparam [2:0] ST_SWITCH = 3'h1;
localparam [2:0] ST_IDLE = 3'h2;
localparam [2:0] ST_WAKE_DLY = 3'h3;
localparam [2:0] ST_ALT_RUN = 3'h4;
localparam [2:0] ST_SLEEP = 3'h5;

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers

wire [4:0] pin_sync;
pmc_sync3 #(
	.WIDTH(5)
) u_sync (
	.clk_in(clk_in),
	.rstn_in(rstn_in),
	.async_in({internal_clk_in, secondary_clk_in, primary_clk_in, secondary_running_in, primary_ready_in}),
	.sync_out(pin_sync)
);

wire pri_rdy = pin_sync[0];
wire sec_running = pin_sync[1];
wire [2:0] tick_lvl = pin_sync[4:2];
reg [2:0] tick_lvl_ff;
wire [2:0] tick_rise = tick_lvl & ~tick_lvl_ff;

////////////////////////////////////////////////////////////////////////////////
// registers and state

reg cpu_idle_select_ff;
reg [2:0] internal_freq_select_ff;
reg [1:0] clock_source_select_ff;
reg secondary_osc_enable_ff;
reg primary_clock_ready_flag_ff;
reg internal_osc_stable_flag_ff;
reg secondary_clock_active_flag_ff;

reg [2:0] state_ff, nxt_state;
reg [1:0] active_src_ff, nxt_active_src;
reg [1:0] tgt_src_ff, nxt_tgt_src;
reg commit_idle_ff, nxt_commit_idle;
reg waking_ff, nxt_waking;
reg pri_low_ff, nxt_pri_low;
reg [3:0] sw_cnt_ff, nxt_sw_cnt;
reg [15:0] dly_cnt_ff, nxt_dly_cnt;
reg [19:0] stable_cnt_ff;
reg int_stable_ff;
reg nxt_wdt_reset, nxt_forced_nop;

// source select decode: 00 primary, 01 secondary, 1x internal
wire [1:0] sel_src = clock_source_select_ff[1] ? `PMC_SRC_INT :
	(clock_source_select_ff[0] ? `PMC_SRC_SEC : `PMC_SRC_PRI);
wire wake_evt = wake_irq_in | wdt_timeout_in;
wire run_state = (state_ff == ST_PRIMARY_RUN_MODE) | (state_ff == ST_ALT_RUN);
wire tgt_tick = tgt_src_ff == `PMC_SRC_SEC ? tick_rise[1] & sec_running :
	(tgt_src_ff == `PMC_SRC_INT ? tick_rise[2] : tick_rise[0]);

////////////////////////////////////////////////////////////////////////////////
// mode state machine

always @* begin
	nxt_state = state_ff;
	nxt_active_src = active_src_ff;
	nxt_tgt_src = tgt_src_ff;
	nxt_commit_idle = commit_idle_ff;
	nxt_waking = waking_ff;
	// a stopped primary shows stale ready for a few cycles through the sync
	nxt_pri_low = pri_low_ff | !pri_rdy;
	nxt_sw_cnt = sw_cnt_ff;
	nxt_dly_cnt = dly_cnt_ff;
	nxt_wdt_reset = 1'b0;
	nxt_forced_nop = 1'b0;
	case (state_ff)
	ST_PRIMARY_RUN_MODE, ST_ALT_RUN: begin
		if (wdt_timeout_in) begin
			// a running cpu owns the watchdog, so time-out resets
			nxt_wdt_reset = 1'b1;
		end
		if (state_ff == ST_ALT_RUN && (wake_irq_in | soft_reset_in | wdt_timeout_in)) begin
			nxt_waking = 1'b1;
		end else if (state_ff == ST_ALT_RUN && waking_ff && pri_rdy && pri_low_ff) begin
			// primary back: switch the system clock to it
			nxt_state = ST_SWITCH;
			nxt_tgt_src = `PMC_SRC_PRI;
			nxt_commit_idle = 1'b0;
			nxt_sw_cnt = 4'h0;
		end else if (power_down_in) begin
			// mode bits sampled on the trigger cycle
			if (sel_src == `PMC_SRC_SEC && !secondary_osc_enable_ff) begin
				nxt_forced_nop = 1'b1;
			end else if (!cpu_idle_select_ff && clock_source_select_ff == 2'h0) begin
				nxt_state = ST_SLEEP;
				nxt_pri_low = 1'b0;
				nxt_active_src = `PMC_SRC_PRI;
				nxt_waking = 1'b0;
			end else if (sel_src != active_src_ff) begin
				nxt_state = ST_SWITCH;
				nxt_tgt_src = sel_src;
				nxt_commit_idle = cpu_idle_select_ff;
				nxt_sw_cnt = 4'h0;
				nxt_waking = 1'b0;
			end else if (cpu_idle_select_ff) begin
				nxt_state = ST_IDLE;
			end
		end
	end
	ST_SWITCH: begin
		// clocks stopped until eight edges of the new source
		if (tgt_tick) begin
			nxt_sw_cnt = sw_cnt_ff + 4'h1;
			if (sw_cnt_ff == `PMC_SWITCH_TICKS - 4'h1) begin
				nxt_active_src = tgt_src_ff;
				nxt_pri_low = 1'b0;
				if (tgt_src_ff == `PMC_SRC_PRI) begin
					nxt_waking = 1'b0;
				end
				if (commit_idle_ff) begin
					nxt_state = ST_IDLE;
				end else if (tgt_src_ff == `PMC_SRC_PRI) begin
					nxt_state = ST_PRIMARY_RUN_MODE;
				end else begin
					nxt_state = ST_ALT_RUN;
				end
			end
		end
	end
	ST_IDLE: begin
		// no trigger reaches here: the cpu is stopped
		if (wake_evt) begin
			nxt_state = ST_WAKE_DLY;
			nxt_dly_cnt = 16'h0000;
		end
	end
	ST_WAKE_DLY: begin
		// cpu start delay on the idle source
		nxt_dly_cnt = dly_cnt_ff + 16'h0001;
		if (dly_cnt_ff >= CPU_START_CYCLES - 16'h0001) begin
			if (active_src_ff == `PMC_SRC_PRI) begin
				nxt_state = ST_PRIMARY_RUN_MODE;
			end else begin
				nxt_state = ST_ALT_RUN;
				nxt_waking = 1'b1;
			end
		end
	end
	ST_SLEEP: begin
		if (wake_evt) begin
			nxt_waking = 1'b1;
		end
		if (waking_ff && pri_rdy && pri_low_ff) begin
			nxt_state = ST_SWITCH;
			nxt_tgt_src = `PMC_SRC_PRI;
			nxt_commit_idle = 1'b0;
			nxt_sw_cnt = 4'h0;
		end
	end
	default: begin
		nxt_state = ST_PRIMARY_RUN_MODE;
	end
	endcase
end

always @(posedge clk_in or negedge rstn_in) begin
	if (!rstn_in) begin
		state_ff <= ST_PRIMARY_RUN_MODE;
		active_src_ff <= `PMC_SRC_PRI;
		tgt_src_ff <= `PMC_SRC_PRI;
		commit_idle_ff <= 1'b0;
		waking_ff <= 1'b0;
		pri_low_ff <= 1'b0;
		sw_cnt_ff <= 4'h0;
		dly_cnt_ff <= 16'h0000;
		tick_lvl_ff <= 3'h0;
		wdt_reset_out <= 1'b0;
		forced_nop_out <= 1'b0;
	end else begin
		state_ff <= nxt_state;
		active_src_ff <= nxt_active_src;
		tgt_src_ff <= nxt_tgt_src;
		commit_idle_ff <= nxt_commit_idle;
		waking_ff <= nxt_waking;
		pri_low_ff <= nxt_pri_low;
		sw_cnt_ff <= nxt_sw_cnt;
		dly_cnt_ff <= nxt_dly_cnt;
		tick_lvl_ff <= tick_lvl;
		wdt_reset_out <= nxt_wdt_reset;
		forced_nop_out <= nxt_forced_nop;
	end
end

////////////////////////////////////////////////////////////////////////////////
// fast internal oscillator stabilisation

wire fast_osc_on = (internal_freq_select_ff != 3'h0) && (state_ff != ST_SLEEP);

always @(posedge clk_in or negedge rstn_in) begin
	if (!rstn_in) begin
		stable_cnt_ff <= 20'h00000;
		int_stable_ff <= 1'b0;
	end else if (!fast_osc_on) begin
		// output disabled, no stable indication
		stable_cnt_ff <= 20'h00000;
		int_stable_ff <= 1'b0;
	end else if (!int_stable_ff) begin
		// stays set once stable, across later triggers except one into sleep
		stable_cnt_ff <= stable_cnt_ff + 20'h00001;
		if (stable_cnt_ff >= FAST_STABLE_CYCLES - 20'h00001) begin
			int_stable_ff <= 1'b1;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// clock control and source flags

always @(posedge clk_in or negedge rstn_in) begin
	if (!rstn_in) begin
		cpu_clk_en_out <= 1'b1;
		periph_clk_en_out <= 1'b1;
		sys_clk_sel_out <= `PMC_SRC_PRI;
		primary_osc_en_out <= 1'b1;
		secondary_osc_en_out <= 1'b0;
		internal_fast_osc_en_out <= 1'b0;
		internal_slow_osc_en_out <= 1'b0;
		primary_clock_ready_flag_ff <= 1'b0;
		internal_osc_stable_flag_ff <= 1'b0;
		secondary_clock_active_flag_ff <= 1'b0;
	end else begin
		cpu_clk_en_out <= (nxt_state == ST_PRIMARY_RUN_MODE) | (nxt_state == ST_ALT_RUN);
		periph_clk_en_out <= (nxt_state != ST_SWITCH) && (nxt_state != ST_SLEEP);
		sys_clk_sel_out <= nxt_active_src;
		// primary stops once another source has taken over
		primary_osc_en_out <= (nxt_active_src == `PMC_SRC_PRI && nxt_state != ST_SLEEP) | nxt_waking |
			(nxt_state == ST_SWITCH && nxt_tgt_src == `PMC_SRC_PRI);
		secondary_osc_en_out <= secondary_osc_enable_ff;
		internal_fast_osc_en_out <= fast_osc_on;
		// a switch to the slow source needs it running before its edges count
		internal_slow_osc_en_out <= wdt_enable_in | failsafe_enable_in |
			(internal_freq_select_ff == 3'h0 && nxt_state != ST_SLEEP && (nxt_active_src == `PMC_SRC_INT ||
			(nxt_state == ST_SWITCH && nxt_tgt_src == `PMC_SRC_INT)));
		// only one flag unless the primary source is active
		primary_clock_ready_flag_ff <= nxt_active_src == `PMC_SRC_PRI && pri_rdy &&
			nxt_state != ST_SWITCH && nxt_state != ST_SLEEP;
		secondary_clock_active_flag_ff <= nxt_active_src == `PMC_SRC_SEC;
		internal_osc_stable_flag_ff <= int_stable_ff && nxt_state != ST_SLEEP &&
			(nxt_active_src == `PMC_SRC_INT || (nxt_active_src == `PMC_SRC_PRI && primary_is_internal_in));
	end
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite slave

reg aw_got_ff;
reg w_got_ff;
reg [7:0] aw_addr_ff;
reg [7:0] w_byte_ff;
reg w_strb_ff;

assign s_axi_awready_out = !aw_got_ff && !s_axi_bvalid_out;
assign s_axi_wready_out = !w_got_ff && !s_axi_bvalid_out;
assign s_axi_arready_out = !s_axi_rvalid_out;

wire do_write = aw_got_ff && w_got_ff && !s_axi_bvalid_out;
wire wr_osc = do_write && aw_addr_ff[7:2] == `PMC_OSC_CTRL_OFS >> 2 && w_strb_ff;
wire wr_sec = do_write && aw_addr_ff[7:2] == `PMC_SEC_CTRL_OFS >> 2 && w_strb_ff;
wire wr_hit = aw_addr_ff[7:2] == `PMC_OSC_CTRL_OFS >> 2 || aw_addr_ff[7:2] == `PMC_SEC_CTRL_OFS >> 2 ||
	aw_addr_ff[7:2] == `PMC_STATUS_OFS >> 2;

always @(posedge clk_in or negedge rstn_in) begin
	if (!rstn_in) begin
		aw_got_ff <= 1'b0;
		w_got_ff <= 1'b0;
		aw_addr_ff <= 8'h00;
		w_byte_ff <= 8'h00;
		w_strb_ff <= 1'b0;
		s_axi_bvalid_out <= 1'b0;
		s_axi_bresp_out <= `PMC_RESP_OKAY;
		cpu_idle_select_ff <= 1'b0;
		internal_freq_select_ff <= 3'h0;
		clock_source_select_ff <= 2'h0;
		secondary_osc_enable_ff <= 1'b0;
	end else begin
		if (s_axi_awvalid_in && s_axi_awready_out) begin
			aw_got_ff <= 1'b1;
			aw_addr_ff <= s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && s_axi_wready_out) begin
			w_got_ff <= 1'b1;
			w_byte_ff <= s_axi_wdata_in[7:0];
			w_strb_ff <= s_axi_wstrb_in[0];
		end
		if (do_write) begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			s_axi_bvalid_out <= 1'b1;
			s_axi_bresp_out <= wr_hit ? `PMC_RESP_OKAY : `PMC_RESP_DECERR;
		end else if (s_axi_bvalid_out && s_axi_bready_in) begin
			s_axi_bvalid_out <= 1'b0;
		end
		// only software writes the mode bits; wake leaves them alone
		if (wr_osc) begin
			cpu_idle_select_ff <= w_byte_ff[`PMC_IDLE_BIT];
			internal_freq_select_ff <= w_byte_ff[`PMC_IFS_HI:`PMC_IFS_LO];
			clock_source_select_ff <= w_byte_ff[`PMC_SCS_HI:`PMC_SCS_LO];
		end
		if (wr_sec) begin
			secondary_osc_enable_ff <= w_byte_ff[`PMC_SEC_EN_BIT];
		end
	end
end

always @(posedge clk_in or negedge rstn_in) begin
	if (!rstn_in) begin
		s_axi_rvalid_out <= 1'b0;
		s_axi_rdata_out <= 32'h00000000;
		s_axi_rresp_out <= `PMC_RESP_OKAY;
	end else if (s_axi_arvalid_in && s_axi_arready_out) begin
		s_axi_rvalid_out <= 1'b1;
		s_axi_rresp_out <= `PMC_RESP_OKAY;
		case (s_axi_araddr_in[7:2])
		`PMC_OSC_CTRL_OFS >> 2: begin
			s_axi_rdata_out <= {24'h000000, cpu_idle_select_ff, internal_freq_select_ff,
				primary_clock_ready_flag_ff, internal_osc_stable_flag_ff, clock_source_select_ff};
		end
		`PMC_SEC_CTRL_OFS >> 2: begin
			s_axi_rdata_out <= {25'h0000000, secondary_clock_active_flag_ff, 2'h0,
				secondary_osc_enable_ff, 3'h0};
		end
		`PMC_STATUS_OFS >> 2: begin
			s_axi_rdata_out <= {24'h000000, waking_ff, state_ff, 2'h0, active_src_ff};
		end
		default: begin
			s_axi_rdata_out <= 32'h00000000;
			s_axi_rresp_out <= `PMC_RESP_DECERR;
		end
		endcase
	end else if (s_axi_rvalid_out && s_axi_rready_in) begin
		s_axi_rvalid_out <= 1'b0;
	end
end

endmodule // pmc_mode_ctrl
`default_nettype wire

/* design/pmc_sync3.v */
// three-stage input synchroniser, output follows once stages two and three agree
`timescale 1ns/100ps
`default_nettype none

module pmc_sync3 #(
	parameter WIDTH = 1
) (
	// clock and reset
	input wire clk_in,
	input wire rstn_in,
	// asynchronous input and filtered output
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] s1_ff;
reg [WIDTH-1:0] s2_ff;
reg [WIDTH-1:0] s3_ff;
reg [WIDTH-1:0] q_ff;

always @(posedge clk_in or negedge rstn_in) begin
	if (!rstn_in) begin
		s1_ff <= {WIDTH{1'b0}};
		s2_ff <= {WIDTH{1'b0}};
		s3_ff <= {WIDTH{1'b0}};
		q_ff <= {WIDTH{1'b0}};
	end else begin
		s1_ff <= async_in;
		s2_ff <= s1_ff;
		s3_ff <= s2_ff;
		// per bit: take the agreed value, else hold
		q_ff <= (s2_ff & s3_ff) | (q_ff & (s2_ff | s3_ff));
	end
end

assign sync_out = q_ff;

endmodule // pmc_sync3
`default_nettype wire

/* sim/pmc_mode_ctrl_chk.sv */
// assertion checker for the power-managed mode controller
`timescale 1ns/100ps
`default_nettype none
module pmc_mode_ctrl_chk #(
	parameter int CPU_START_CYCLES = 1000
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// inputs
	input wire logic wake_irq_in,
	input wire logic s_axi_bready_in,
	input wire logic s_axi_rready_in,
	// outputs
	input wire logic cpu_clk_en_out,
	input wire logic periph_clk_en_out,
	input wire logic [1:0] sys_clk_sel_out,
	input wire logic primary_osc_en_out,
	input wire logic wdt_reset_out,
	input wire logic forced_nop_out,
	input wire logic s_axi_bvalid_out,
	input wire logic [1:0] s_axi_bresp_out,
	input wire logic s_axi_rvalid_out,
	input wire logic [31:0] s_axi_rdata_out
);
	localparam int WMIN = CPU_START_CYCLES - 2;
	localparam int WMAX = CPU_START_CYCLES + 6;
	logic [7:0] off_ff;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	////////////////////
	// cycles with peripherals stopped, saturating
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in)
			off_ff <= 8'h00;
		else if (periph_clk_en_out)
			off_ff <= 8'h00;
		else if (off_ff != 8'hff)
			off_ff <= off_ff + 8'h01;
	end
	sequence wake_idle;
		$rose(wake_irq_in) && !cpu_clk_en_out && periph_clk_en_out;
	endsequence
	AST_CPU_NEEDS_PERIPH: assert property (cpu_clk_en_out |-> periph_clk_en_out)
		else $error("cpu clocked while peripherals stopped");
	AST_WAKE_HOLD: assert property (wake_idle |=> !cpu_clk_en_out [*6])
		else $error("cpu resumed too soon after wake");
	AST_WAKE_RESUME: assert property (wake_idle |-> ##[WMIN:WMAX] cpu_clk_en_out)
		else $error("cpu did not resume after wake");
	// 36 cycles: under the span of eight edges of the fastest source used in simulation
	AST_SWITCH_PAUSE: assert property ($rose(periph_clk_en_out) |-> off_ff >= 8'h24)
		else $error("clock switch pause too short");
	AST_PRI_OSC_ON: assert property (sys_clk_sel_out == 2'h0 && periph_clk_en_out |-> primary_osc_en_out)
		else $error("primary source in use but stopped");
	AST_WDT_RUN_ONLY: assert property (wdt_reset_out |-> $past(cpu_clk_en_out))
		else $error("watchdog reset outside run mode");
	AST_NOP_PULSE: assert property (forced_nop_out |=> !forced_nop_out && cpu_clk_en_out)
		else $error("forced no-op not a single pulse");
	AST_B_HOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write response dropped early");
	AST_R_HOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
		else $error("read data dropped early");
	COV_IDLE: cover property ($fell(cpu_clk_en_out) && periph_clk_en_out);
	COV_WAKE: cover property (wake_idle);
	COV_WDT: cover property (wdt_reset_out);
	COV_NOP: cover property (forced_nop_out);
endmodule // pmc_mode_ctrl_chk

bind pmc_mode_ctrl pmc_mode_ctrl_chk #(.CPU_START_CYCLES(CPU_START_CYCLES)) u_chk (
	.clk_in, .rstn_in, .wake_irq_in, .s_axi_bready_in, .s_axi_rready_in, .cpu_clk_en_out,
	.periph_clk_en_out, .sys_clk_sel_out, .primary_osc_en_out, .wdt_reset_out, .forced_nop_out,
	.s_axi_bvalid_out, .s_axi_bresp_out, .s_axi_rvalid_out, .s_axi_rdata_out
);
`default_nettype wire

/* sim/pmc_mode_ctrl_tb.sv */
// testbench for the power-managed mode controller
`timescale 1ns/100ps
`default_nettype none
module pmc_mode_ctrl_tb;
	logic clk_in, rstn_in, sec_hold;
	logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
	logic [31:0] s_axi_wdata_in;
	logic [3:0] s_axi_wstrb_in;
	logic s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
	logic power_down_in, wake_irq_in, soft_reset_in, wdt_timeout_in;
	logic wdt_enable_in, failsafe_enable_in, primary_is_internal_in;
	wire logic primary_ready_in, secondary_running_in, primary_clk_in, secondary_clk_in, internal_clk_in;
	wire logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
	wire logic [1:0] s_axi_bresp_out, s_axi_rresp_out, sys_clk_sel_out;
	wire logic [31:0] s_axi_rdata_out;
	wire logic cpu_clk_en_out, periph_clk_en_out, primary_osc_en_out, secondary_osc_en_out;
	wire logic internal_fast_osc_en_out, internal_slow_osc_en_out, wdt_reset_out, forced_nop_out;
	int mismatches = 0;
	int n_checks = 0;
	int nops = 0;
	int wrs = 0;
	pmc_mode_ctrl #(.CPU_START_CYCLES(16'd8), .FAST_STABLE_CYCLES(20'd20)) u_dut (
		.clk_in, .rstn_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in,
		.s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out,
		.s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
		.s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .power_down_in, .wake_irq_in,
		.soft_reset_in, .wdt_timeout_in, .wdt_enable_in, .failsafe_enable_in, .primary_is_internal_in,
		.primary_ready_in, .secondary_running_in, .primary_clk_in, .secondary_clk_in, .internal_clk_in,
		.cpu_clk_en_out, .periph_clk_en_out, .sys_clk_sel_out, .primary_osc_en_out, .secondary_osc_en_out,
		.internal_fast_osc_en_out, .internal_slow_osc_en_out, .wdt_reset_out, .forced_nop_out
	);
	pmc_osc_model u_osc (
		.pri_en_in(primary_osc_en_out), .sec_en_in(secondary_osc_en_out),
		.int_en_in(internal_fast_osc_en_out | internal_slow_osc_en_out), .sec_hold_in(sec_hold),
		.pri_clk_out(primary_clk_in), .sec_clk_out(secondary_clk_in), .int_clk_out(internal_clk_in),
		.pri_rdy_out(primary_ready_in), .secondary_run_mode_out(secondary_running_in)
	);
	////////////////////
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	// ready raised late on purpose so the slave must hold its answer
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
			output logic [1:0] r);
		int n;
		@(posedge clk_in);
		if (w) begin
			s_axi_awaddr_in <= a;
			s_axi_wdata_in <= d;
			s_axi_awvalid_in <= 1'b1;
			s_axi_wvalid_in <= 1'b1;
		end else begin
			s_axi_araddr_in <= a;
			s_axi_arvalid_in <= 1'b1;
		end
		n = 0;
		// no local limit: only the watchdog ends a hung transfer
		forever begin
			@(posedge clk_in);
			if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
			if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
			if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
			if (s_axi_bvalid_out && s_axi_bready_in || s_axi_rvalid_out && s_axi_rready_in) break;
			s_axi_bready_in <= w && n >= 2;
			s_axi_rready_in <= !w && n >= 1;
			n++;
		end
		{s_axi_bready_in, s_axi_rready_in} <= 2'h0;
		q = s_axi_rdata_out;
		r = w ? s_axi_bresp_out : s_axi_rresp_out;
		chk("bus handshake", 32'h0, 32'(w ? s_axi_rvalid_out : s_axi_bvalid_out));
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] q;
		logic [1:0] r;
		bus(1'b0, a, 32'h0, q, r);
		chk("read data", e, q);
		chk("read resp", 32'(er), 32'(r));
	endtask
	task automatic wc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [31:0] q;
		logic [1:0] r;
		bus(1'b1, a, d, q, r);
		chk("write resp", 32'(er), 32'(r));
	endtask
	// 0 power-down, 1 software reset, 2 watchdog time-out
	task automatic pls(input int k);
		@(posedge clk_in);
		power_down_in <= k == 0;
		soft_reset_in <= k == 1;
		wdt_timeout_in <= k == 2;
		@(posedge clk_in);
		{power_down_in, soft_reset_in, wdt_timeout_in} <= 3'h0;
	endtask
	task automatic wu(input logic [1:0] s, input logic c, input logic p);
		int n;
		for (n = 0; n < 3000; n++) begin
			if (sys_clk_sel_out === s && cpu_clk_en_out === c && periph_clk_en_out === p) break;
			@(posedge clk_in);
		end
		chk("clock state", 32'({c, p, s}), 32'({cpu_clk_en_out, periph_clk_en_out, sys_clk_sel_out}));
	endtask
	task automatic wake();
		@(posedge clk_in);
		wake_irq_in <= 1'b1;
	endtask
	////////////////////
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		if (forced_nop_out === 1'b1) nops++;
		if (wdt_reset_out === 1'b1) wrs++;
	end
	initial begin
		#400000;
		mismatches++;
		conclude();
	end
	initial begin
		{rstn_in, sec_hold, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 5'h0;
		{s_axi_arvalid_in, s_axi_rready_in, power_down_in, wake_irq_in, soft_reset_in} = 5'h0;
		{wdt_timeout_in, wdt_enable_in, failsafe_enable_in, primary_is_internal_in} = 4'h0;
		{s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 48'h0;
		s_axi_wstrb_in = 4'hf;
		repeat (8) @(posedge clk_in);
		rstn_in <= 1'b1;
		repeat (200) @(posedge clk_in);
		rc(8'h00, 32'h08, 2'h0);
		rc(8'h04, 32'h00, 2'h0);
		wc(8'h08, 32'hff, 2'h0);
		rc(8'h08, 32'h00, 2'h0);
		wc(8'h0c, 32'h01, 2'h3);
		rc(8'h0c, 32'h00, 2'h3);
		wc(8'h00, 32'h80, 2'h0);
		pls(0);
		wu(2'h0, 1'b0, 1'b1);
		rc(8'h00, 32'h88, 2'h0);
		pls(1);
		pls(0);
		repeat (20) @(posedge clk_in);
		wu(2'h0, 1'b0, 1'b1);
		pls(2);
		wu(2'h0, 1'b1, 1'b1);
		chk("watchdog resets", 32'h0, 32'(wrs));
		rc(8'h00, 32'h88, 2'h0);
		wc(8'h00, 32'h81, 2'h0);
		pls(0);
		repeat (4) @(posedge clk_in);
		chk("forced no-op", 32'h1, 32'(nops));
		wu(2'h0, 1'b1, 1'b1);
		sec_hold <= 1'b1;
		wc(8'h04, 32'h08, 2'h0);
		wc(8'h00, 32'h01, 2'h0);
		pls(0);
		repeat (100) @(posedge clk_in);
		chk("held peripherals", 32'h0, 32'(periph_clk_en_out));
		sec_hold <= 1'b0;
		wu(2'h1, 1'b1, 1'b1);
		rc(8'h04, 32'h48, 2'h0);
		wc(8'h00, 32'h81, 2'h0);
		pls(0);
		wu(2'h1, 1'b0, 1'b1);
		chk("primary osc", 32'h0, 32'(primary_osc_en_out));
		rc(8'h00, 32'h81, 2'h0);
		wake();
		wu(2'h1, 1'b1, 1'b1);
		wake_irq_in <= 1'b0;
		wu(2'h0, 1'b1, 1'b1);
		rc(8'h04, 32'h08, 2'h0);
		rc(8'h00, 32'h89, 2'h0);
		chk("secondary osc", 32'h1, 32'(secondary_osc_en_out));
		wc(8'h00, 32'h01, 2'h0);
		pls(0);
		wu(2'h1, 1'b1, 1'b1);
		pls(1);
		wu(2'h0, 1'b1, 1'b1);
		wc(8'h00, 32'h13, 2'h0);
		pls(0);
		wu(2'h2, 1'b1, 1'b1);
		repeat (60) @(posedge clk_in);
		rc(8'h00, 32'h17, 2'h0);
		pls(2);
		repeat (4) @(posedge clk_in);
		chk("watchdog resets", 32'h1, 32'(wrs));
		wu(2'h0, 1'b1, 1'b1);
		rc(8'h00, 32'h1b, 2'h0);
		primary_is_internal_in <= 1'b1;
		rc(8'h00, 32'h1f, 2'h0);
		primary_is_internal_in <= 1'b0;
		wc(8'h00, 32'h82, 2'h0);
		pls(0);
		wu(2'h2, 1'b0, 1'b1);
		chk("slow osc", 32'h1, 32'(internal_slow_osc_en_out));
		rc(8'h00, 32'h82, 2'h0);
		chk("fast osc", 32'h0, 32'(internal_fast_osc_en_out));
		wake();
		wu(2'h2, 1'b1, 1'b1);
		wake_irq_in <= 1'b0;
		wu(2'h0, 1'b1, 1'b1);
		rc(8'h00, 32'h8a, 2'h0);
		failsafe_enable_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		chk("slow osc", 32'h1, 32'(internal_slow_osc_en_out));
		{failsafe_enable_in, wdt_enable_in} <= 2'h1;
		repeat (2) @(posedge clk_in);
		chk("slow osc", 32'h1, 32'(internal_slow_osc_en_out));
		wdt_enable_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		chk("slow osc", 32'h0, 32'(internal_slow_osc_en_out));
		wc(8'h00, 32'h00, 2'h0);
		pls(0);
		wu(2'h0, 1'b0, 1'b0);
		chk("primary osc", 32'h0, 32'(primary_osc_en_out));
		wake();
		wu(2'h0, 1'b1, 1'b1);
		wake_irq_in <= 1'b0;
		rc(8'h00, 32'h08, 2'h0);
		conclude();
	end
endmodule // pmc_mode_ctrl_tb
`default_nettype wire

/* sim/pmc_osc_model.sv */
// behavioural oscillator sources facing the mode controller
`timescale 1ns/100ps
`default_nettype none
module pmc_osc_model (
	// enables
	input wire logic pri_en_in,
	input wire logic sec_en_in,
	input wire logic int_en_in,
	input wire logic sec_hold_in,
	// clocks and status
	output var logic pri_clk_out,
	output var logic sec_clk_out,
	output var logic int_clk_out,
	output var logic pri_rdy_out,
	output var logic secondary_run_mode_out
);
	int pri_edges = 0;
	////////////////////
	// clocks stand still while stopped; periods unrelated to clk_in
	initial {pri_clk_out, sec_clk_out, int_clk_out} = 3'h0;
	always #31 if (pri_en_in) pri_clk_out = ~pri_clk_out;
	always #47 if (secondary_run_mode_out) sec_clk_out = ~sec_clk_out;
	always #37 if (int_en_in) int_clk_out = ~int_clk_out;
	// start-up count before the primary reports ready
	always @(posedge pri_clk_out or negedge pri_en_in) begin
		if (!pri_en_in)
			pri_edges <= 0;
		else if (pri_edges < 16)
			pri_edges <= pri_edges + 1;
	end
	assign pri_rdy_out = pri_en_in && pri_edges == 16;
	// held: enabled but not yet oscillating
	assign secondary_run_mode_out = sec_en_in && !sec_hold_in;
endmodule // pmc_osc_model
`default_nettype wire
